// *** i2c_bus_master.sv ***
// Purpose: Far end: bus master that writes and reads device registers
// Assumes: One command at a time; device pulls lines only low
// Notes:   Bus clock made from system clock in quarter steps;
//          waits while the device stretches the clock
`timescale 1ns/10ps
module i2c_bus_master (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  i2c_link_if.master      bus,
  input  wire logic       i2c_select,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_read,
  input  wire logic [6:0] cmd_address,
  input  wire logic [7:0] cmd_sub,
  input  wire logic [7:0] cmd_length,
  input  wire logic       wdata_valid,
  output logic            wdata_ready,
  input  wire logic [7:0] wdata,
  output logic [7:0]      rdata,
  output logic            rdata_valid,
  output logic            done,
  output logic            nack
);
  typedef enum {M_IDLE, M_START, M_LOAD, M_BIT, M_STOP} master_state_e;
  typedef enum {SEG_ADDR_W, SEG_SUB, SEG_WDATA, SEG_ADDR_R, SEG_RDATA}
    segment_e;

  localparam logic [7:0] STEP_LAST = 8'(i2c_pkg::STEP_CYC - 1);

  master_state_e state;
  segment_e      seg;
  logic [7:0]    step_cnt;
  logic          tick;
  logic [1:0]    ph;
  logic [1:0]    pin_meta;
  logic [1:0]    pin_sync;
  logic          scl_low;
  logic          sda_low;
  logic          sel;
  logic          rd;
  logic [6:0]    addr;
  logic [7:0]    sub;
  logic [7:0]    left;
  logic [7:0]    tx;
  logic [7:0]    rx;
  logic [3:0]    cnt;
  logic          ack_in;
  logic [7:0]    next_byte;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pin_meta <= 2'h3;
      pin_sync <= 2'h3;
    end else begin
      pin_meta <= {bus.scl, bus.sda};
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      step_cnt <= 8'h00;
    end else begin
      step_cnt <= tick ? 8'h00 : step_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sel <= 1'h0;
    end else begin
      sel <= i2c_select;
    end
  end

  assign tick                 = step_cnt == STEP_LAST;
  assign bus.interface_select = sel;
  assign bus.m_scl_o          = 1'h0;
  assign bus.m_sda_o          = 1'h0;
  assign bus.m_scl_oe_n       = ~scl_low;
  assign bus.m_sda_oe_n       = ~sda_low;
  assign cmd_ready            = state == M_IDLE;
  assign wdata_ready          = state == M_LOAD && seg == SEG_WDATA;

  always_comb begin
    unique case (seg)
      SEG_ADDR_W: next_byte = {addr, ~i2c_pkg::RW_READ};
      SEG_SUB:    next_byte = sub;
      SEG_WDATA:  next_byte = wdata;
      SEG_ADDR_R: next_byte = {addr, i2c_pkg::RW_READ};
      SEG_RDATA:  next_byte = 8'hFF;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= M_IDLE;
      seg   <= SEG_ADDR_W;
      ph    <= 2'h0;
      scl_low <= 1'h0;
      sda_low <= 1'h0;
      rd    <= 1'h0;
      addr  <= 7'h00;
      sub   <= 8'h00;
      left  <= 8'h00;
      tx    <= 8'h00;
      rx    <= 8'h00;
      cnt   <= 4'h0;
      ack_in <= 1'h0;
      rdata <= 8'h00;
      rdata_valid <= 1'h0;
      done  <= 1'h0;
      nack  <= 1'h0;
    end else begin
      rdata_valid <= 1'h0;
      done        <= 1'h0;
      unique case (state)
        M_IDLE: begin
          if (cmd_valid) begin
            rd    <= cmd_read;
            addr  <= cmd_address;
            sub   <= cmd_sub;
            left  <= (cmd_read && cmd_length == 8'h00) ? 8'h01
                                                       : cmd_length;
            seg   <= SEG_ADDR_W;
            nack  <= 1'h0;
            ph    <= 2'h0;
            state <= M_START;
          end
        end
        M_START: begin
          if (tick) begin
            unique case (ph)
              2'h0: begin
                sda_low <= 1'h0;
                ph      <= 2'h1;
              end
              2'h1: begin
                scl_low <= 1'h0;
                ph      <= 2'h2;
              end
              2'h2: begin
                if (pin_sync == 2'h3) begin
                  sda_low <= 1'h1;
                  ph      <= 2'h3;
                end
              end
              2'h3: begin
                scl_low <= 1'h1;
                state   <= M_LOAD;
              end
            endcase
          end
        end
        M_LOAD: begin
          if (seg != SEG_WDATA || wdata_valid) begin
            tx      <= next_byte;
            sda_low <= ~next_byte[7];
            cnt     <= 4'h0;
            ph      <= 2'h0;
            state   <= M_BIT;
          end
        end
        M_BIT: begin
          if (tick) begin
            unique case (ph)
              2'h0: begin
                scl_low <= 1'h0;
                ph      <= 2'h1;
              end
              2'h1: begin
                if (pin_sync[1]) begin
                  if (cnt == 4'h8) begin
                    ack_in <= pin_sync[0];
                  end else begin
                    rx <= {rx[6:0], pin_sync[0]};
                  end
                  ph <= 2'h2;
                end
              end
              2'h2: begin
                scl_low <= 1'h1;
                ph      <= 2'h3;
              end
              2'h3: begin
                ph <= 2'h0;
                if (cnt != 4'h8) begin
                  cnt <= cnt + 4'h1;
                  tx  <= {tx[6:0], 1'h1};
                  if (cnt == 4'h7) begin
                    sda_low <= seg == SEG_RDATA && left != 8'h01;
                  end else begin
                    sda_low <= ~tx[6];
                  end
                end else begin
                  sda_low <= 1'h0;
                  unique case (seg)
                    SEG_ADDR_W, SEG_ADDR_R: begin
                      nack  <= ack_in;
                      state <= ack_in ? M_STOP : M_LOAD;
                      seg   <= seg == SEG_ADDR_W ? SEG_SUB : SEG_RDATA;
                    end
                    SEG_SUB: begin
                      nack <= ack_in;
                      if (ack_in || (!rd && left == 8'h00)) begin
                        state <= M_STOP;
                      end else if (rd) begin
                        seg   <= SEG_ADDR_R;
                        state <= M_START;
                      end else begin
                        seg   <= SEG_WDATA;
                        state <= M_LOAD;
                      end
                    end
                    SEG_WDATA: begin
                      nack  <= ack_in;
                      left  <= left - 8'h01;
                      state <= (ack_in || left == 8'h01) ? M_STOP : M_LOAD;
                    end
                    SEG_RDATA: begin
                      rdata       <= rx;
                      rdata_valid <= 1'h1;
                      left        <= left - 8'h01;
                      state <= (left <= 8'h01) ? M_STOP : M_LOAD;
                    end
                  endcase
                end
              end
            endcase
          end
        end
        M_STOP: begin
          if (tick) begin
            unique case (ph)
              2'h0: begin
                sda_low <= 1'h1;
                ph      <= 2'h1;
              end
              2'h1: begin
                scl_low <= 1'h0;
                ph      <= 2'h2;
              end
              2'h2: begin
                if (pin_sync[1]) begin
                  sda_low <= 1'h0;
                  ph      <= 2'h3;
                end
              end
              2'h3: begin
                done  <= 1'h1;
                state <= M_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end
endmodule

// *** i2c_link_if.sv ***
// Purpose: Shared two-wire bus and interface select between the two ends
// Assumes: Both lines pulled up; each end pulls low only
// Notes:   Enables are active low, output value always low
`timescale 1ns/10ps
interface i2c_link_if;
  logic interface_select;
  logic m_scl_o;
  logic m_scl_oe_n;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic s_scl_o;
  logic s_scl_oe_n;
  logic s_sda_o;
  logic s_sda_oe_n;
  logic scl;
  logic sda;

  // Wired-AND of the open-drain drivers with pull-up
  assign scl = ~((~m_scl_oe_n & ~m_scl_o) | (~s_scl_oe_n & ~s_scl_o));
  assign sda = ~((~m_sda_oe_n & ~m_sda_o) | (~s_sda_oe_n & ~s_sda_o));

  modport master (output interface_select, m_scl_o, m_scl_oe_n,
                  output m_sda_o, m_sda_oe_n, input scl, sda);
  modport device (input interface_select, scl, sda,
                  output s_scl_o, s_scl_oe_n, s_sda_o, s_sda_oe_n);
endinterface

// *** i2c_pkg.sv ***
// Purpose: Shared constants for the serial register link and its two ends
// Assumes: System clock of 50 MHz
// Notes:   Bus clock is made by the master end from the system clock
package i2c_pkg;

  localparam int CLK_PERIOD_NS = 20;
  // Bus clock period, kept long enough to stay below the 400 kHz ceiling
  localparam int SCL_PERIOD_NS = 2600;
  // One quarter of a bus clock period in system cycles, rounded up
  localparam int STEP_CYC =
    (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

  localparam logic [5:0] ADDR_PREFIX = 6'h2E;
  localparam logic       RW_READ     = 1'h1;
  localparam int         BYTE_BITS   = 8;
  localparam int         REG_AW      = 7;
  localparam int         FIFO_DEPTH  = 4;

  typedef logic [REG_AW-1:0] reg_addr_t;

endpackage

// *** sensor_i2c_register_slave_bench.sv ***
// Purpose: Bench joining master and device ends over the link
// Assumes: Bench acts as the register file behind the device
// Notes:   Expected register contents are kept in exp_m
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
  err_count++; $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); \
  end end
module sensor_i2c_register_slave_bench;
  logic               clk_sys = 1'b0;
  logic               reset_n = 1'b0;
  logic               i2c_select = 1'b1;
  logic               cmd_valid = 1'b0;
  logic               cmd_read = 1'b0;
  logic [6:0]         cmd_address = 7'h00;
  logic [7:0]         cmd_sub = 8'h00;
  logic [7:0]         cmd_length = 8'h00;
  logic               wdata_valid = 1'b0;
  logic [7:0]         wdata = 8'h00;
  logic               strap = 1'b1;
  logic               three_wire = 1'b0;
  logic               auto_inc = 1'b1;
  logic [7:0]         rd_data = 8'h00;
  logic               rd_valid = 1'b0;
  logic               wr_ready = 1'b1;
  logic               cmd_ready, wdata_ready, rdata_valid, done, nack;
  logic               spi_mode, bus_busy, rd_req, wr_valid;
  logic [7:0]         rdata, wr_data;
  i2c_pkg::reg_addr_t rd_addr, wr_addr;
  logic [7:0]         mem [128] = '{default: 8'h00};
  logic [7:0]         exp_m [128] = '{default: 8'h00};
  logic [7:0]         wq [$];
  logic [7:0]         rq [$];
  int                 err_count = 0;
  int                 cmp_count = 0;
  int                 cycles = 0;
  int                 k;
  wire [6:0]          own = {i2c_pkg::ADDR_PREFIX, strap};

  i2c_link_if link ();
  i2c_bus_master u_i2c_bus_master (.clk_sys(clk_sys), .reset_n(reset_n),
    .bus(link.master), .i2c_select(i2c_select), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_address(cmd_address),
    .cmd_sub(cmd_sub), .cmd_length(cmd_length), .wdata_valid(wdata_valid),
    .wdata_ready(wdata_ready), .wdata(wdata), .rdata(rdata),
    .rdata_valid(rdata_valid), .done(done), .nack(nack));
  sensor_i2c_slave u_sensor_i2c_slave (.clk_sys(clk_sys),
    .reset_n(reset_n), .bus(link.device), .address_lsb_strap(strap),
    .three_wire_select(three_wire), .auto_increment(auto_inc),
    .spi_three_wire_mode(spi_mode), .bus_busy(bus_busy), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
    .wr_data(wr_data));
  sensor_i2c_register_slave_chk u_sensor_i2c_register_slave_chk (
    .clk_sys(clk_sys), .reset_n(reset_n),
    .interface_select(link.interface_select),
    .m_scl_oe_n(link.m_scl_oe_n), .m_sda_oe_n(link.m_sda_oe_n),
    .s_scl_o(link.s_scl_o), .s_scl_oe_n(link.s_scl_oe_n),
    .s_sda_o(link.s_sda_o), .s_sda_oe_n(link.s_sda_oe_n),
    .scl(link.scl), .sda(link.sda));

  always #10 clk_sys = ~clk_sys;

  // Register file and write-data source behind the two ends
  always @(negedge clk_sys) begin
    rd_valid <= rd_req && !rd_valid;
    rd_data <= mem[rd_addr];
    wdata_valid <= wq.size() != 0;
    wdata <= (wq.size() != 0) ? wq[0] : 8'h00;
  end

  always @(posedge clk_sys) begin
    if (wr_valid && wr_ready) mem[wr_addr] <= wr_data;
    if (wdata_valid && wdata_ready) void'(wq.pop_front());
    if (rdata_valid) rq.push_back(rdata);
    cycles++;
    if (cycles == 95000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("compares=%0d mismatches=%0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic xfer(input logic r, input logic [6:0] a,
                      input logic [7:0] s, input logic [7:0] n);
    cmd_read = r;
    cmd_address = a;
    cmd_sub = s;
    cmd_length = n;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    while (done !== 1'b1) @(negedge clk_sys);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] s,
                    input int n, input logic [7:0] d, input logic ok);
    logic [6:0] p;
    p = s[6:0];
    for (int i = 0; i < n; i++) begin
      wq.push_back(d + 8'(i * 8'h11));
      if (ok) exp_m[p] = d + 8'(i * 8'h11);
      if (ok && auto_inc) p++;
    end
    xfer(1'b0, a, s, 8'(n));
    wq.delete();
    `CHK(nack, !ok)
    repeat (5) @(negedge clk_sys);
    `CHK(bus_busy, 1'b0)
    for (int i = 0; i < 128; i++) `CHK(mem[i], exp_m[i])
  endtask

  task automatic rd(input logic [7:0] s, input int n);
    logic [6:0] p;
    p = s[6:0];
    rq.delete();
    xfer(1'b1, own, s, 8'(n));
    `CHK(rq.size(), n)
    for (int i = 0; i < n; i++) begin
      `CHK(rq[i], exp_m[p])
      if (auto_inc) p++;
    end
  endtask

  initial begin
    repeat (12) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (5) @(negedge clk_sys);
    wr(own, 8'h85, 3, 8'hA1, 1'b1);
    rd(8'h05, 3);
    $display("test burst write and read done");
    auto_inc = 1'b0;
    wr(own, 8'h10, 2, 8'h11, 1'b1);
    rd(8'h10, 2);
    auto_inc = 1'b1;
    $display("test fixed pointer done");
    for (int s = 0; s < 2; s++) begin
      strap = s[0];
      repeat (5) @(negedge clk_sys);
      wr({i2c_pkg::ADDR_PREFIX, ~strap}, 8'h20, 1, 8'h5A, 1'b0);
      wr(own, 8'h20 + 8'(s), 1, 8'h5A, 1'b1);
    end
    $display("test address strap done");
    wr_ready = 1'b0;
    fork
      wr(own, 8'h30, 6, 8'h40, 1'b1);
      begin
        k = 0;
        while (k < 100) begin
          @(negedge clk_sys);
          k = (link.s_scl_oe_n === 1'b0) ? k + 1 : 0;
        end
        `CHK(link.scl, 1'b0)
        `CHK(wr_valid, 1'b1)
        `CHK(bus_busy, 1'b1)
        wr_ready = 1'b1;
      end
    join
    rd(8'h30, 6);
    $display("test full buffer stall done");
    i2c_select = 1'b0;
    three_wire = 1'b1;
    repeat (5) @(negedge clk_sys);
    `CHK(spi_mode, 1'b1)
    wr(own, 8'h50, 1, 8'h77, 1'b0);
    i2c_select = 1'b1;
    repeat (5) @(negedge clk_sys);
    `CHK(spi_mode, 1'b0)
    three_wire = 1'b0;
    wr(own, 8'h50, 1, 8'h77, 1'b1);
    $display("test interface select done");
    report_and_stop();
  end
endmodule

// *** sensor_i2c_register_slave_chk.sv ***
// Purpose: Bus-level checks on the link joining both ends
// Assumes: Signals taken straight from the link interface
// Notes:   Device drive may change only while the bus clock is low
`timescale 1ns/10ps
module sensor_i2c_register_slave_chk (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic interface_select,
  input wire logic m_scl_oe_n,
  input wire logic m_sda_oe_n,
  input wire logic s_scl_o,
  input wire logic s_scl_oe_n,
  input wire logic s_sda_o,
  input wire logic s_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_select_idle: assert property (
    (!interface_select)[*4] |-> s_sda_oe_n && s_scl_oe_n)
    else $error("device drives while deselected");
  a_drive_low: assert property (
    s_sda_o == 1'b0 && s_scl_o == 1'b0)
    else $error("device output value not low");
  a_stretch_held: assert property (
    $fell(s_scl_oe_n) |-> !m_scl_oe_n)
    else $error("stretch begun while clock released");
  a_stretch_bound: assert property (
    $fell(s_scl_oe_n) |-> ##[1:1000] s_scl_oe_n)
    else $error("clock stretch never ends");
  a_sda_lag: assert property (
    $changed(s_sda_oe_n) |-> !scl && $past(scl, 2) == 1'b0)
    else $error("device data changed near clock high");
  a_ack_hold: assert property (
    $rose(scl) && !s_sda_oe_n |-> (!s_sda_oe_n)[*8])
    else $error("device low level not held");
  a_no_cond: assert property (
    scl && $past(scl) && $changed(sda)
      |-> s_sda_oe_n && $past(s_sda_oe_n))
    else $error("device made a start or stop");
  a_tx_release: assert property (
    !s_sda_oe_n && scl |-> m_sda_oe_n)
    else $error("both ends drive data at once");

  c_stretch: cover property ($fell(s_scl_oe_n));
  c_ack: cover property ($rose(scl) && !s_sda_oe_n);
  c_start: cover property (scl && $fell(sda));
endmodule

// *** sensor_i2c_slave.sv ***
// Purpose: Device end: two-wire register access slave with sub-address
// Assumes: Bus lines and select pin come from outside the clock domain
// Notes:   Writes queue in a FIFO; a full FIFO or a pending read
//          answer stretches the bus clock
`timescale 1ns/10ps
// Behaviour
// - Select high enables bus; low ignores it
// - Serial port mode selectable three or four wire
// - Three-wire mode when control bit is one
// - START is data falling, clock high; busy
// - First byte: address plus direction, must match
// - Address 101110 plus strap bit
// - Transmitter releases data; receiver holds low
// - Receiver acknowledges each received byte, except the master's last read byte
// - Sub-address byte, low seven bits used
// - Auto-increment bit advances pointer per byte
// - Master reads via sub-address, repeated START
// - Master writes data right after sub-address
// - Master NACKs last byte; device releases
// - Eight-bit units, MSB first, unlimited count
// - Receiver may hold clock low to stall
// - No address ACK leaves data high
// - STOP is data rising, clock high
// - Works at standard and fast rates
module sensor_i2c_slave #(
  parameter int FIFO_DEPTH = i2c_pkg::FIFO_DEPTH
) (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  i2c_link_if.device             bus,
  input  wire logic              address_lsb_strap,
  input  wire logic              three_wire_select,
  input  wire logic              auto_increment,
  output logic                   spi_three_wire_mode,
  output logic                   bus_busy,
  output logic                   rd_req,
  output i2c_pkg::reg_addr_t     rd_addr,
  input  wire logic [7:0]        rd_data,
  input  wire logic              rd_valid,
  output logic                   wr_valid,
  input  wire logic              wr_ready,
  output i2c_pkg::reg_addr_t     wr_addr,
  output logic      [7:0]        wr_data
);
  typedef enum {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK, ST_WDATA,
    ST_PUSH, ST_WACK, ST_RLOAD, ST_RDATA, ST_RACK, ST_IGNORE
  } slave_state_e;

  localparam logic [3:0] FULL_CNT = 4'(i2c_pkg::BYTE_BITS);

  slave_state_e       state;
  logic [3:0]         pin_meta;
  logic [3:0]         pin_sync;
  logic               scl_d;
  logic               sda_d;
  logic               scl_s;
  logic               sda_s;
  logic               sel_s;
  logic               strap_s;
  logic               scl_rise;
  logic               scl_fall;
  logic               start_seen;
  logic               stop_seen;
  logic [7:0]         shreg;
  logic [3:0]         cnt;
  logic               rw;
  logic               master_ack;
  logic               sda_low;
  logic               scl_hold;
  i2c_pkg::reg_addr_t ptr;
  logic               push_ready;
  logic               wr_ready_int;

  // Two-stage synchronisers for clock, data, select and strap
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pin_meta <= 4'hF;
      pin_sync <= 4'hF;
    end else begin
      pin_meta <= {bus.scl, bus.sda, bus.interface_select,
                   address_lsb_strap};
      pin_sync <= pin_meta;
    end
  end

  assign scl_s   = pin_sync[3];
  assign sda_s   = pin_sync[2];
  assign sel_s   = pin_sync[1];
  assign strap_s = pin_sync[0];

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      scl_d <= 1'h1;
      sda_d <= 1'h1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Edges are seen within three system cycles, far inside a bus phase
  assign scl_rise   = scl_s & ~scl_d;
  assign scl_fall   = ~scl_s & scl_d;
  assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_seen  = scl_s & scl_d & ~sda_d & sda_s;

  // Open-drain drivers: enable low pulls the line low
  assign bus.s_sda_o    = 1'h0;
  assign bus.s_scl_o    = 1'h0;
  assign bus.s_sda_oe_n = ~sda_low;
  assign bus.s_scl_oe_n = ~scl_hold;

  assign rd_req   = state == ST_RLOAD;
  assign rd_addr  = ptr;
  assign push_ready = (state == ST_PUSH);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      spi_three_wire_mode <= 1'h0;
    end else begin
      spi_three_wire_mode <= three_wire_select & ~sel_s;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n || !sel_s) begin
      bus_busy <= 1'h0;
    end else if (start_seen) begin
      bus_busy <= 1'h1;
    end else if (stop_seen) begin
      bus_busy <= 1'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state      <= ST_IDLE;
      shreg      <= 8'h00;
      cnt        <= 4'h0;
      rw         <= 1'h0;
      master_ack <= 1'h0;
      sda_low    <= 1'h0;
      scl_hold   <= 1'h0;
      ptr        <= '0;
    end else if (!sel_s) begin
      state    <= ST_IDLE;
      sda_low  <= 1'h0;
      scl_hold <= 1'h0;
    end else if (start_seen) begin
      state    <= ST_ADDR;
      cnt      <= 4'h0;
      sda_low  <= 1'h0;
      scl_hold <= 1'h0;
    end else if (stop_seen) begin
      state    <= ST_IDLE;
      sda_low  <= 1'h0;
      scl_hold <= 1'h0;
    end else begin
      unique case (state)
        ST_IDLE, ST_IGNORE: begin
          sda_low <= 1'h0;
        end
        ST_ADDR, ST_SUB, ST_WDATA: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s};
            cnt   <= cnt + 4'h1;
          end else if (scl_fall && cnt == FULL_CNT) begin
            if (state == ST_ADDR) begin
              if (shreg[7:1] == {i2c_pkg::ADDR_PREFIX, strap_s}) begin
                sda_low <= 1'h1;
                rw      <= shreg[0];
                state   <= ST_ADDR_ACK;
              end else begin
                state   <= ST_IGNORE;
              end
            end else if (state == ST_SUB) begin
              ptr     <= shreg[6:0];
              sda_low <= 1'h1;
              state   <= ST_SUB_ACK;
            end else begin
              scl_hold <= 1'h1;
              state    <= ST_PUSH;
            end
          end
        end
        ST_PUSH: begin
          if (wr_ready_int) begin
            sda_low  <= 1'h1;
            state    <= ST_WACK;
          end
        end
        ST_ADDR_ACK, ST_SUB_ACK, ST_WACK: begin
          // Stall ends a cycle after the acknowledge settles
          scl_hold <= 1'h0;
          if (scl_fall) begin
            sda_low <= 1'h0;
            cnt     <= 4'h0;
            if (state == ST_ADDR_ACK && rw == i2c_pkg::RW_READ) begin
              scl_hold <= 1'h1;
              state    <= ST_RLOAD;
            end else if (state == ST_ADDR_ACK) begin
              state <= ST_SUB;
            end else begin
              state <= ST_WDATA;
              if (state == ST_WACK && auto_increment) begin
                ptr <= ptr + i2c_pkg::reg_addr_t'(1);
              end
            end
          end
        end
        ST_RLOAD: begin
          if (rd_valid) begin
            shreg    <= rd_data;
            sda_low  <= ~rd_data[7];
            cnt      <= 4'h0;
            state    <= ST_RDATA;
          end
        end
        ST_RDATA: begin
          // Clock let go only after the first bit is on the line
          scl_hold <= 1'h0;
          if (scl_rise) begin
            cnt <= cnt + 4'h1;
          end else if (scl_fall) begin
            if (cnt == FULL_CNT) begin
              sda_low <= 1'h0;
              state   <= ST_RACK;
            end else begin
              shreg   <= {shreg[6:0], 1'h0};
              sda_low <= ~shreg[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            master_ack <= ~sda_s;
          end else if (scl_fall) begin
            if (auto_increment && master_ack) begin
              ptr <= ptr + i2c_pkg::reg_addr_t'(1);
            end
            if (master_ack) begin
              scl_hold <= 1'h1;
              state    <= ST_RLOAD;
            end else begin
              state <= ST_IGNORE;
            end
          end
        end
      endcase
    end
  end

  sync_fifo #(
    .WIDTH (i2c_pkg::REG_AW + i2c_pkg::BYTE_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .in_valid  (push_ready),
    .in_ready  (wr_ready_int),
    .in_data   ({ptr, shreg}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  ({wr_addr, wr_data})
  );
endmodule

// *** sync_fifo.sv ***
// Purpose: Small first-in first-out buffer with valid/ready on both sides
// Assumes: DEPTH is a power of two, at least 2
// Notes:   Read data is the array word at the read pointer
`timescale 1ns/10ps
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("sync_fifo DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;

  assign out_valid = wr_ptr != rd_ptr;
  assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) &&
                       (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wr_ptr <= '0;
    end else if (in_valid && in_ready) begin
      wr_ptr <= wr_ptr + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rd_ptr <= '0;
    end else if (out_valid && out_ready) begin
      rd_ptr <= rd_ptr + (AW+1)'(1);
    end
  end
endmodule
